// File: hw/hfc_fb_reg.sv
/*
  Feedback loop configuration register with decoded outputs.
  Assumes a register port (address, write strobe, data) on mclk from the
  device's serial interface and a calibration engine on the same clock.
*/
// Function
// - Bit 7 selects rotating mass (0) or linear resonant (1).
// - Bits 6-4 pick brake ratio 1,2,3,4,6,8,16x; code 7 disables.
// - Bits 3-2 set settling speed: low, medium, high, very high.
// - Bits 1-0 are amp gain, meaning depends on actuator type.
// - Calibration overwrites the amp gain field with its result.
// - Level equals byte/255 times 1.22 V over amp gain field plus one.
`timescale 1ns/1ps
`include "hfc_consts.svh"
module hfc_fb_reg (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  output      logic [7:0]        reg_rdata,
  // Calibration result
  input  wire logic              cal_done,
  input  wire logic [1:0]        cal_amp,
  input  wire logic [7:0]        cal_level,
  // Settings to the loop
  output      hfc_pkg::hfc_dec_t dec_out,
  output      logic [11:0]       level_mv
);
  typedef struct packed {
    hfc_pkg::hfc_cfg_t cfg;
    logic [7:0]        rdata;
    hfc_pkg::hfc_dec_t dec;
    logic [11:0]       lvl;
  } hfc_state_t;

  hfc_state_t st_r;
  hfc_state_t st_nxt;
  logic [11:0] lvl_calc;

  function automatic logic [4:0] brake_mult(input logic [2:0] code);
    case (code)
      3'h0:    brake_mult = 5'h01;
      3'h1:    brake_mult = 5'h02;
      3'h2:    brake_mult = 5'h03;
      3'h3:    brake_mult = 5'h04;
      3'h4:    brake_mult = 5'h06;
      3'h5:    brake_mult = 5'h08;
      3'h6:    brake_mult = 5'h10;
      default: brake_mult = 5'h00;
    endcase
  endfunction : brake_mult

  function automatic logic sel(input logic [7:0] a);
    sel = (a == `HFC_ADDR_FB_CFG);
  endfunction : sel

  // Calibration sees the amp setting in force, not its own result of the same cycle
  hfc_level_calc u_lvl (
    .cal_level   (cal_level),
    .amp_setting (st_r.cfg.amp_setting),
    .level_mv    (lvl_calc)
  );

  always_comb begin
    st_nxt = st_r;
    if (reg_wr && sel(reg_addr)) begin
      st_nxt.cfg.act_type =
        hfc_pkg::hfc_act_t'(reg_wdata[`HFC_BIT_ACT_TYPE]);
      st_nxt.cfg.brake_ratio = reg_wdata[`HFC_BRAKE_HI:`HFC_BRAKE_LO];
      st_nxt.cfg.loop_speed  = reg_wdata[`HFC_LOOP_HI:`HFC_LOOP_LO];
      st_nxt.cfg.amp_setting = reg_wdata[`HFC_AMP_HI:`HFC_AMP_LO];
    end
    if (cal_done) begin
      st_nxt.cfg.amp_setting = cal_amp;
    end
    st_nxt.rdata = sel(reg_addr) ? 8'(st_nxt.cfg) : 8'h00;
    st_nxt.dec.act_type = st_nxt.cfg.act_type;
    st_nxt.dec.brake_en   = (st_nxt.cfg.brake_ratio != `HFC_BRAKE_OFF);
    st_nxt.dec.brake_mult = brake_mult(st_nxt.cfg.brake_ratio);
    st_nxt.dec.loop_speed = st_nxt.cfg.loop_speed;
    st_nxt.dec.amp_setting = st_nxt.cfg.amp_setting;
    st_nxt.lvl = lvl_calc;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r.cfg   <= hfc_pkg::hfc_cfg_t'(`HFC_RST_FB_CFG);
      st_r.rdata <= 8'h00;
      st_r.dec   <= '{hfc_pkg::HFC_ERM, 1'b1, 5'h04, 2'h1, 2'h2};
      st_r.lvl   <= 12'h000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign dec_out   = st_r.dec;
  assign level_mv  = st_r.lvl;

  // Calibration owns only the amp field

  a_cal_overwrite: assert property (
    @(posedge mclk) disable iff (!nrst)
    cal_done |=> st_r.cfg.amp_setting == $past(cal_amp))
    else $error("calibration amp not stored");

  a_cal_keep: assert property (
    @(posedge mclk) disable iff (!nrst)
    cal_done && !reg_wr |=> $stable(st_r.cfg.act_type) &&
    $stable(st_r.cfg.brake_ratio) && $stable(st_r.cfg.loop_speed))
    else $error("calibration touched other fields");

  // Brake ratio decode, one code at a time

  a_brake_off: assert property (
    @(posedge mclk) disable iff (!nrst)
    dec_out.brake_en == (st_r.cfg.brake_ratio != `HFC_BRAKE_OFF))
    else $error("brake enable mismatch");

  a_brake_none: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h7 |-> dec_out.brake_mult == 5'h00)
    else $error("disabled brake has a ratio");

  a_brake_1x: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h0 |-> dec_out.brake_mult == 5'h01)
    else $error("brake ratio 1x wrong");

  a_brake_2x: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h1 |-> dec_out.brake_mult == 5'h02)
    else $error("brake ratio 2x wrong");

  a_brake_3x: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h2 |-> dec_out.brake_mult == 5'h03)
    else $error("brake ratio 3x wrong");

  a_brake_4x: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h3 |-> dec_out.brake_mult == 5'h04)
    else $error("brake ratio 4x wrong");

  a_brake_6x: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h4 |-> dec_out.brake_mult == 5'h06)
    else $error("brake ratio 6x wrong");

  a_brake_8x: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h5 |-> dec_out.brake_mult == 5'h08)
    else $error("brake ratio 8x wrong");

  a_brake_max: assert property (
    @(posedge mclk) disable iff (!nrst)
    st_r.cfg.brake_ratio == 3'h6 |-> dec_out.brake_mult == 5'h10)
    else $error("brake ratio 16x wrong");

  // Host writes land in the next cycle, the amp field only without a calibration in the same cycle; elsewhere only calibration moves the amp field

  a_type_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `HFC_ADDR_FB_CFG
    |=> dec_out.act_type == $past(reg_wdata[`HFC_BIT_ACT_TYPE]))
    else $error("actuator type not applied");

  a_type_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(reg_wr && reg_addr == `HFC_ADDR_FB_CFG)
    |=> $stable(dec_out.act_type))
    else $error("actuator type changed unasked");

  a_loop_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `HFC_ADDR_FB_CFG
    |=> dec_out.loop_speed == $past(reg_wdata[`HFC_LOOP_HI:`HFC_LOOP_LO]))
    else $error("settling speed not applied");

  a_loop_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(reg_wr && reg_addr == `HFC_ADDR_FB_CFG)
    |=> $stable(dec_out.loop_speed))
    else $error("settling speed changed unasked");

  a_amp_follow: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `HFC_ADDR_FB_CFG && !cal_done
    |=> dec_out.amp_setting == $past(reg_wdata[`HFC_AMP_HI:`HFC_AMP_LO]))
    else $error("amp setting not applied");

  a_amp_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    !cal_done && !(reg_wr && reg_addr == `HFC_ADDR_FB_CFG)
    |=> $stable(dec_out.amp_setting))
    else $error("amp setting changed unasked");

  a_amp_pair: assert property (
    @(posedge mclk) disable iff (!nrst)
    dec_out.amp_setting == st_r.cfg.amp_setting &&
    dec_out.act_type == st_r.cfg.act_type)
    else $error("amp setting split from type");

  a_wr_other: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr != `HFC_ADDR_FB_CFG && !cal_done
    |=> $stable(st_r.cfg))
    else $error("foreign write changed register");

  // Readback

  a_read_back: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_addr == `HFC_ADDR_FB_CFG && !reg_wr && !cal_done ##1
    reg_addr == `HFC_ADDR_FB_CFG && !reg_wr && !cal_done
    |=> reg_rdata == 8'(st_r.cfg))
    else $error("readback differs from stored byte");

  a_rd_other: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_addr != `HFC_ADDR_FB_CFG |=> reg_rdata == 8'h00)
    else $error("foreign read not zero");

  // Level scaling, end points

  a_level_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    cal_level == 8'h00 |=> level_mv == 12'h000)
    else $error("zero level not zero");

  a_level_max: assert property (
    @(posedge mclk) disable iff (!nrst)
    cal_level == 8'hFF && st_r.cfg.amp_setting == 2'h0
    |=> level_mv == 12'h4C4)
    else $error("full level at unit gain wrong");

  a_level_gain3: assert property (
    @(posedge mclk) disable iff (!nrst)
    cal_level == 8'hFF && st_r.cfg.amp_setting == 2'h3
    |=> level_mv == 12'h131)
    else $error("full level at top gain wrong");
endmodule : hfc_fb_reg

// File: common/hfc_consts.svh
/*
  Offsets, field positions, reset values and codes of the feedback loop
  configuration register. Assumes it is included by bare name.
*/
`ifndef HFC_CONSTS_SVH
`define HFC_CONSTS_SVH
`define HFC_ADDR_FB_CFG     8'h1A
`define HFC_RST_FB_CFG      8'h36
`define HFC_BIT_ACT_TYPE    7
`define HFC_BRAKE_HI        6
`define HFC_BRAKE_LO        4
`define HFC_LOOP_HI         3
`define HFC_LOOP_LO         2
`define HFC_AMP_HI          1
`define HFC_AMP_LO          0
`define HFC_BRAKE_OFF       3'h7
`define HFC_BEMF_FULL_MV    1220
`define HFC_BEMF_FULL_CODE  255
`endif

// File: common/hfc_pkg.sv
/*
  Types of the feedback loop configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hfc_pkg;
  typedef enum logic [0:0] {
    HFC_ERM = 1'b0,
    HFC_LRA = 1'b1
  } hfc_act_t;

  typedef struct packed {
    hfc_act_t   act_type;
    logic [2:0] brake_ratio;
    logic [1:0] loop_speed;
    logic [1:0] amp_setting;
  } hfc_cfg_t;

  // Decoded settings handed to the loop controller
  typedef struct packed {
    hfc_act_t   act_type;
    logic       brake_en;
    logic [4:0] brake_mult;
    logic [1:0] loop_speed;
    logic [1:0] amp_setting;
  } hfc_dec_t;
endpackage : hfc_pkg

// File: hw/hfc_level_calc.sv
/*
  Scales the calibrated back-EMF byte into millivolts.
  Assumes the gain divisor is the stored setting plus one, so no zero divide.
*/
`timescale 1ns/1ps
`include "hfc_consts.svh"
module hfc_level_calc (
  // Inputs
  input  wire logic [7:0]  cal_level,
  input  wire logic [1:0]  amp_setting,
  // Result
  output      logic [11:0] level_mv
);
  logic [19:0] prod;
  logic [19:0] scaled;
  logic [19:0] divided;

  always_comb begin
    prod    = 20'(cal_level) * 20'(`HFC_BEMF_FULL_MV);
    scaled  = prod / 20'(`HFC_BEMF_FULL_CODE);
    divided = scaled / (20'(amp_setting) + 20'h00001);
    level_mv = divided[11:0];
  end
endmodule : hfc_level_calc

// File: verification/hfc_host_model.sv
/* Host register writer on the device register port.
   Assumes the bench calls its tasks, one at a time. */
`timescale 1ns/1ps
`include "hfc_consts.svh"
module hfc_host_model (
  // Register port
  input  wire logic       mclk,
  output      logic [7:0] reg_addr,
  output      logic       reg_wr,
  output      logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'hA5;
  end
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // Released data must not look valid
    reg_wdata <= ~d;
  endtask : wr
  task automatic sel(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
  endtask : sel
  task automatic prep(input logic [7:0] d);
    wr(`HFC_ADDR_FB_CFG, d);
  endtask : prep
endmodule : hfc_host_model

// File: verification/tb_hfc_fb_reg.sv
/* Bench for the feedback loop configuration register.
   Assumes the host model; calibration pulses come from here. */
`timescale 1ns/1ps
`include "hfc_consts.svh"
module tb_hfc_fb_reg;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  logic              cal_done = 1'b0;
  logic [1:0]        cal_amp = 2'h0;
  logic [7:0]        cal_level = 8'hFF;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata;
  logic              reg_wr;
  logic [11:0]       level_mv;
  hfc_pkg::hfc_dec_t dec_out;
  int                failures = 0;
  int                num_checks = 0;
  logic [4:0]        mult [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                  5'h06, 5'h08, 5'h10, 5'h00};
  always #4 mclk = ~mclk;
  hfc_host_model u_host (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  hfc_fb_reg u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cal_done(cal_done), .cal_amp(cal_amp), .cal_level(cal_level),
    .dec_out(dec_out), .level_mv(level_mv));
  task automatic check(input string nm, input logic [11:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s exp %0h got %0h", nm, exp, got);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, exp);
    u_host.sel(a);
    @(posedge mclk);
    #1 check("rdata", {4'h0, exp}, {4'h0, reg_rdata});
  endtask : rd
  task automatic pulse(input logic [1:0] amp);
    @(posedge mclk);
    cal_done <= 1'b1;
    cal_amp <= amp;
    @(posedge mclk);
    cal_done <= 1'b0;
  endtask : pulse
  task automatic test_reset;
    rd(8'h1A, `HFC_RST_FB_CFG);
    check("dec", {3'h1, 5'h04, 2'h1, 2'h2}, dec_out);
    check("level", 12'h196, level_mv);
    rd(8'h1B, 8'h00);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_brake;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], i[2:0], i[1:0], ~i[1:0]};
      u_host.wr(8'h1A, d);
      #1 check("dec", {1'b0, d[7], i != 7, mult[i], d[3:0]}, dec_out);
      rd(8'h1A, d);
    end
    $display("test_brake done");
  endtask : test_brake
  task automatic test_cal;
    u_host.prep(8'hF3);
    @(posedge mclk);
    #1 check("level", 12'h131, level_mv);
    pulse(2'h1);
    rd(8'h1A, 8'hF1);
    check("level", 12'h262, level_mv);
    fork
      u_host.wr(8'h1A, 8'h81);
      pulse(2'h2);
    join
    rd(8'h1A, 8'h82);
    u_host.wr(8'h1B, 8'h00);
    rd(8'h1A, 8'h82);
    @(posedge mclk);
    cal_level <= 8'h00;
    @(posedge mclk);
    #1 check("level", 12'h000, level_mv);
    @(posedge mclk);
    cal_level <= 8'hFF;
    $display("test_cal done");
  endtask : test_cal
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    test_reset();
    test_brake();
    test_cal();
    print_verdict();
  end
endmodule : tb_hfc_fb_reg
